// *** rtl/cafl_regs.vh ***
// Register offsets, field positions and reset values of the acceptance filter.
`ifndef CAFL_REGS_VH
`define CAFL_REGS_VH
`define CAFL_OFF_CTRL       8'h00
`define CAFL_OFF_STATUS     8'h04
`define CAFL_OFF_BUF0_CTL   8'h08
`define CAFL_OFF_BUF1_CTL   8'h0c
`define CAFL_OFF_BUF0_ID    8'h10
`define CAFL_OFF_BUF1_ID    8'h14
`define CAFL_OFF_FILT_BASE  8'h20
`define CAFL_OFF_FILT_STEP  8'h04
`define CAFL_FILT_PAGE      3'h1
`define CAFL_OFF_MASK0      8'h40
`define CAFL_OFF_MASK1      8'h44
`define CAFL_CTRL_CFG       0
`define CAFL_CTRL_DBEN      1
`define CAFL_CTRL_CFG_RST   1'b1
`define CAFL_CTRL_DBEN_RST  1'b0
`define CAFL_CTL_FULL       3
`define CAFL_STAT_FULL0     0
`define CAFL_STAT_FULL1     1
`define CAFL_STAT_OVF       2
`define CAFL_STAT_BUSY      3
`define CAFL_HIT_RST        3'h0
`define CAFL_HIT_ROLL_HI    2'h3
`define CAFL_HIT_LOW_HI     2'h0
`define CAFL_NUM_FILT       6
`define CAFL_NUM_FILT_B0    2
`endif

// *** rtl/cafl_match.v ***
// One acceptance filter compared bit by bit against a frame identifier.
`timescale 1ns/10ps
module cafl_match
#(
    parameter ID_W = 29
)
(
    input  wire [ID_W-1:0] id,
    input  wire [ID_W-1:0] filt,
    input  wire [ID_W-1:0] mask,
    output wire            hit
);
    // A cleared mask bit accepts the position; a set one demands equality.
    assign hit = &(~mask | ~(id ^ filt));
endmodule

// *** rtl/cafl_prio.v ***
// Priority encoder that picks the lowest-numbered matching filter.
`timescale 1ns/10ps
module cafl_prio
(
    input  wire [5:0] hits,
    output reg  [2:0] code,
    output reg        any
);
    integer i;
    always @*
    begin
        code = 3'h0;
        any  = 1'b0;
        // Walk upward and keep the first hit met.
        for (i = 0; i < 6; i = i + 1)
        begin
            if (hits[i] && !any)
            begin
                code = i[2:0];
                any  = 1'b1;
            end
        end
    end
endmodule

// *** rtl/cafl_top.v ***
// Acceptance filter with two receive buffers behind a Wishbone slave.
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "cafl_regs.vh"
module cafl_top
#(
    parameter ID_W = 29
)
(
    input  wire            CLK,
    input  wire            SRST,
    input  wire            WB_CYC_I,
    input  wire            WB_STB_I,
    input  wire            WB_WE_I,
    input  wire [7:0]      WB_ADR_I,
    input  wire [3:0]      WB_SEL_I,
    input  wire [31:0]     WB_DAT_I,
    output reg  [31:0]     WB_DAT_O,
    output reg             WB_ACK_O,
    input  wire            FRAME_VALID,
    input  wire [ID_W-1:0] FRAME_ID,
    output reg             BUSY,
    output reg             BUF0_LOAD,
    output reg             BUF1_LOAD,
    output reg             BUF0_FULL,
    output reg             BUF1_FULL,
    output reg  [ID_W-1:0] BUF0_ID,
    output reg  [ID_W-1:0] BUF1_ID,
    output reg  [2:0]      BUF0_HIT,
    output reg  [2:0]      BUF1_HIT
);
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_CMP   = 3'b010;
    localparam [2:0] ST_STORE = 3'b100;
    localparam       NF       = `CAFL_NUM_FILT;
    localparam       PAD      = 32 - ID_W;

    // Byte-lane merge shared by every writable identifier register.
    function [ID_W-1:0] merge;
        input [ID_W-1:0] old;
        input [31:0]     wdat;
        input [3:0]      sel;
        reg   [31:0]     tmp;
        integer          b;
        begin
            tmp = {{PAD{1'b0}}, old};
            for (b = 0; b < 4; b = b + 1)
            begin
                if (sel[b])
                begin
                    tmp[8*b +: 8] = wdat[8*b +: 8];
                end
            end
            merge = tmp[ID_W-1:0];
        end
    endfunction

    reg  [2:0]         state_q;
    reg  [2:0]         state_d;
    reg  [ID_W-1:0]    id_q;
    reg  [NF-1:0]      hits_q;
    wire [NF*ID_W-1:0] filt_q;
    reg  [ID_W-1:0]    mask0_q;
    reg  [ID_W-1:0]    mask1_q;
    reg                cfg_q;
    reg                dben_q;
    reg                ovf_q;
    reg                ovf_d;
    reg                full0_d;
    reg                full1_d;
    reg                load0_d;
    reg                load1_d;
    reg                drop_d;
    reg  [2:0]         code0_d;
    reg  [2:0]         code1_d;
    reg                roll_d;
    reg  [31:0]        rdat_d;
    wire [NF-1:0]      hit_vec;
    wire [2:0]         prio_code;
    wire               prio_any;
    wire               any_b0;
    wire               wb_req;
    wire               wb_wr;
    wire [2:0]         filt_idx;
    wire               filt_page;
    wire               clr0;
    wire               clr1;
    wire               clr_ovf;

    assign wb_req    = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wb_wr     = wb_req & WB_WE_I;
    assign filt_idx  = WB_ADR_I[4:2];
    assign filt_page = (WB_ADR_I[7:5] == `CAFL_FILT_PAGE) &&
                       (WB_ADR_I[1:0] == 2'h0) &&
                       (filt_idx < 3'h6);
    assign clr0      = wb_wr && (WB_ADR_I == `CAFL_OFF_BUF0_CTL) &&
                       WB_SEL_I[0] && WB_DAT_I[`CAFL_CTL_FULL];
    assign clr1      = wb_wr && (WB_ADR_I == `CAFL_OFF_BUF1_CTL) &&
                       WB_SEL_I[0] && WB_DAT_I[`CAFL_CTL_FULL];
    assign clr_ovf   = wb_wr && (WB_ADR_I == `CAFL_OFF_STATUS) &&
                       WB_SEL_I[0] && WB_DAT_I[`CAFL_STAT_OVF];

    genvar gi;
    generate
        for (gi = 0; gi < NF; gi = gi + 1)
        begin : g_filt
            localparam integer OFF_SUM = `CAFL_OFF_FILT_BASE +
                                         `CAFL_OFF_FILT_STEP * gi;
            localparam [7:0]   OFF     = OFF_SUM[7:0];
            wire [ID_W-1:0] use_mask;
            reg  [ID_W-1:0] value_q;
            // First two filters belong to buffer zero's mask.
            assign use_mask = (gi < `CAFL_NUM_FILT_B0) ?
                              mask0_q : mask1_q;
            cafl_match #(.ID_W(ID_W)) u_match
            (
                .id   (id_q),
                .filt (value_q),
                .mask (use_mask),
                .hit  (hit_vec[gi])
            );
            always @(posedge CLK)
            begin
                if (SRST)
                begin
                    value_q <= {ID_W{1'b0}};
                end
                else if (wb_wr && cfg_q && WB_ADR_I == OFF)
                begin
                    value_q <= merge(value_q, WB_DAT_I, WB_SEL_I);
                end
            end
            assign filt_q[gi*ID_W +: ID_W] = value_q;
        end
    endgenerate

    cafl_prio u_prio
    (
        .hits (hits_q),
        .code (prio_code),
        .any  (prio_any)
    );

    assign any_b0 = |hits_q[`CAFL_NUM_FILT_B0-1:0];

    // Bus slave: one wait state, every access acknowledged.
    always @(posedge CLK)
    begin
        if (SRST)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0;
            cfg_q    <= `CAFL_CTRL_CFG_RST;
            dben_q   <= `CAFL_CTRL_DBEN_RST;
            mask0_q  <= {ID_W{1'b0}};
            mask1_q  <= {ID_W{1'b0}};
        end
        else
        begin
            WB_ACK_O <= wb_req;
            WB_DAT_O <= wb_req ? rdat_d : 32'h0;
            if (wb_wr && WB_ADR_I == `CAFL_OFF_CTRL && WB_SEL_I[0])
            begin
                cfg_q  <= WB_DAT_I[`CAFL_CTRL_CFG];
                dben_q <= WB_DAT_I[`CAFL_CTRL_DBEN];
            end
            if (wb_wr && cfg_q && WB_ADR_I == `CAFL_OFF_MASK0)
            begin
                mask0_q <= merge(mask0_q, WB_DAT_I, WB_SEL_I);
            end
            if (wb_wr && cfg_q && WB_ADR_I == `CAFL_OFF_MASK1)
            begin
                mask1_q <= merge(mask1_q, WB_DAT_I, WB_SEL_I);
            end
        end
    end

    // Read mux; unmapped offsets read as zero.
    always @*
    begin
        rdat_d = 32'h0;
        case (WB_ADR_I)
            `CAFL_OFF_CTRL:
            begin
                rdat_d[`CAFL_CTRL_CFG]  = cfg_q;
                rdat_d[`CAFL_CTRL_DBEN] = dben_q;
            end
            `CAFL_OFF_STATUS:
            begin
                rdat_d[`CAFL_STAT_FULL0] = BUF0_FULL;
                rdat_d[`CAFL_STAT_FULL1] = BUF1_FULL;
                rdat_d[`CAFL_STAT_OVF]   = ovf_q;
                rdat_d[`CAFL_STAT_BUSY]  = BUSY;
            end
            `CAFL_OFF_BUF0_CTL:
            begin
                rdat_d[2:0]            = BUF0_HIT;
                rdat_d[`CAFL_CTL_FULL] = BUF0_FULL;
            end
            `CAFL_OFF_BUF1_CTL:
            begin
                rdat_d[2:0]            = BUF1_HIT;
                rdat_d[`CAFL_CTL_FULL] = BUF1_FULL;
            end
            `CAFL_OFF_BUF0_ID:
            begin
                rdat_d = {{PAD{1'b0}}, BUF0_ID};
            end
            `CAFL_OFF_BUF1_ID:
            begin
                rdat_d = {{PAD{1'b0}}, BUF1_ID};
            end
            `CAFL_OFF_MASK0:
            begin
                rdat_d = cfg_q ? {{PAD{1'b0}}, mask0_q} : 32'h0;
            end
            `CAFL_OFF_MASK1:
            begin
                rdat_d = cfg_q ? {{PAD{1'b0}}, mask1_q} : 32'h0;
            end
            default:
            begin
                if (filt_page && cfg_q)
                begin
                    rdat_d = {{PAD{1'b0}}, filt_q[filt_idx*ID_W +: ID_W]};
                end
            end
        endcase
    end

    // Storage decision, taken once the match vector is settled.
    always @*
    begin
        load0_d = 1'b0;
        load1_d = 1'b0;
        drop_d  = 1'b0;
        roll_d  = 1'b0;
        code0_d = BUF0_HIT;
        code1_d = BUF1_HIT;
        if (state_q == ST_STORE && prio_any)
        begin
            if (any_b0)
            begin
                if (!BUF0_FULL)
                begin
                    load0_d = 1'b1;
                    code0_d = {`CAFL_HIT_LOW_HI, prio_code[0]};
                end
                else if (dben_q && !BUF1_FULL)
                begin
                    load1_d = 1'b1;
                    roll_d  = 1'b1;
                    code1_d = {`CAFL_HIT_LOW_HI, prio_code[0]};
                    code0_d = {`CAFL_HIT_ROLL_HI, prio_code[0]};
                end
                else
                begin
                    drop_d = 1'b1;
                end
            end
            else if (!BUF1_FULL)
            begin
                load1_d = 1'b1;
                code1_d = prio_code;
            end
            else
            begin
                drop_d = 1'b1;
            end
        end
        // A load in the same cycle as a release leaves the buffer full.
        full0_d = (BUF0_FULL & ~clr0) | load0_d;
        full1_d = (BUF1_FULL & ~clr1) | load1_d;
        ovf_d   = (ovf_q & ~clr_ovf) | drop_d;
    end

    always @*
    begin
        case (state_q)
            ST_IDLE:
            begin
                state_d = FRAME_VALID ? ST_CMP : ST_IDLE;
            end
            ST_CMP:
            begin
                state_d = ST_STORE;
            end
            ST_STORE:
            begin
                state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Frames that arrive while a decision is pending are not seen.
    always @(posedge CLK)
    begin
        if (SRST)
        begin
            state_q   <= ST_IDLE;
            id_q      <= {ID_W{1'b0}};
            hits_q    <= {NF{1'b0}};
            BUSY      <= 1'b0;
            BUF0_LOAD <= 1'b0;
            BUF1_LOAD <= 1'b0;
            BUF0_FULL <= 1'b0;
            BUF1_FULL <= 1'b0;
            BUF0_ID   <= {ID_W{1'b0}};
            BUF1_ID   <= {ID_W{1'b0}};
            BUF0_HIT  <= `CAFL_HIT_RST;
            BUF1_HIT  <= `CAFL_HIT_RST;
            ovf_q     <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            BUSY      <= (state_d != ST_IDLE);
            if (state_q == ST_IDLE && FRAME_VALID)
            begin
                id_q <= FRAME_ID;
            end
            if (state_q == ST_CMP)
            begin
                hits_q <= hit_vec;
            end
            BUF0_LOAD <= load0_d;
            BUF1_LOAD <= load1_d;
            BUF0_FULL <= full0_d;
            BUF1_FULL <= full1_d;
            ovf_q     <= ovf_d;
            BUF0_HIT  <= code0_d;
            BUF1_HIT  <= code1_d;
            if (load0_d)
            begin
                BUF0_ID <= id_q;
            end
            if (load1_d)
            begin
                BUF1_ID <= id_q;
            end
        end
    end
endmodule

// *** sim/cafl_top_sva.sv ***
// Concurrent checks on the ports of the acceptance filter.
`timescale 1ns/10ps
module cafl_chk
#(
    parameter ID_W = 29
)
(
    input wire logic            CLK,
    input wire logic            SRST,
    input wire logic            WB_CYC_I,
    input wire logic            WB_STB_I,
    input wire logic            WB_ACK_O,
    input wire logic [31:0]     WB_DAT_O,
    input wire logic            FRAME_VALID,
    input wire logic            BUSY,
    input wire logic            BUF0_LOAD,
    input wire logic            BUF1_LOAD,
    input wire logic            BUF0_FULL,
    input wire logic            BUF1_FULL,
    input wire logic [2:0]      BUF0_HIT,
    input wire logic [2:0]      BUF1_HIT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    ack_one_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    ack_delay_a: assert property (
        (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
        else $error("ack not one cycle after request");
    data_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data not zero outside ack");
    decide_time_a: assert property (
        (FRAME_VALID && !BUSY) |=> BUSY [*2] ##1 !BUSY)
        else $error("decision time not two cycles");
    load_origin_a: assert property (
        (BUF0_LOAD || BUF1_LOAD) |-> $past(FRAME_VALID && !BUSY, 3))
        else $error("buffer loaded without a taken frame");
    load_single_a: assert property (!(BUF0_LOAD && BUF1_LOAD))
        else $error("both buffers loaded by one frame");
    b0_code_a: assert property (
        BUF0_LOAD |-> BUF0_FULL && BUF0_HIT[2:1] == 2'b00)
        else $error("buffer zero load with wrong code");
    roll_mark_a: assert property (
        (BUF1_LOAD && BUF1_HIT[2:1] == 2'b00) |->
        BUF0_FULL && BUF0_HIT[2:1] == 2'b11)
        else $error("rollover without full buffer zero");
    b1_range_a: assert property (
        BUF1_LOAD |-> BUF1_FULL && BUF1_HIT <= 3'h5)
        else $error("buffer one code out of range");
endmodule
bind cafl_top cafl_chk #(.ID_W(ID_W)) cafl_chk_i (.CLK(CLK), .SRST(SRST),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
    .WB_DAT_O(WB_DAT_O), .FRAME_VALID(FRAME_VALID), .BUSY(BUSY),
    .BUF0_LOAD(BUF0_LOAD), .BUF1_LOAD(BUF1_LOAD), .BUF0_FULL(BUF0_FULL),
    .BUF1_FULL(BUF1_FULL), .BUF0_HIT(BUF0_HIT), .BUF1_HIT(BUF1_HIT));

// *** sim/cafl_frame_src.sv ***
// Frame assembly model that hands one identifier per request to the filter.
`timescale 1ns/10ps
module cafl_frame_src
#(
    parameter ID_W = 29
)
(
    input  wire logic            CLK,
    input  wire logic            SRST,
    input  wire logic            GO,
    input  wire logic [ID_W-1:0] ID_IN,
    input  wire logic            BUSY,
    output logic                 FRAME_VALID,
    output logic      [ID_W-1:0] FRAME_ID
);
    initial
    begin
        FRAME_VALID = 1'b0;
        FRAME_ID = '0;
    end
    // Outside a valid pulse the identifier keeps moving, so the filter
    // cannot get away with sampling it late.
    always @(posedge CLK)
    begin
        if (!SRST && GO && !BUSY && !FRAME_VALID)
        begin
            FRAME_VALID <= 1'b1;
            FRAME_ID <= ID_IN;
        end
        else
        begin
            FRAME_VALID <= 1'b0;
            FRAME_ID <= ~FRAME_ID;
        end
    end
endmodule

// *** sim/cafl_tb_top.sv ***
// Directed bench for the acceptance filter over Wishbone and the frame path.
`timescale 1ns/10ps
`include "cafl_regs.vh"
module cafl_tb_top;
    localparam ID_W = 11;
    logic            clk, srst, cyc, stb, we, go, fv, busy, ack;
    logic            ld0, ld1, full0, full1, l0, l1;
    logic [7:0]      adr;
    logic [31:0]     dati, dato, q;
    logic [3:0]      sel;
    logic [ID_W-1:0] fid, gid, id0, id1;
    logic [2:0]      hit0, hit1;
    logic [31:0]     flt [6] = '{32'h120, 32'h130, 32'h200, 32'h300,
                                 32'h200, 32'h555};
    int              err_total, n_checks, cyc_cnt;

    cafl_top #(.ID_W(ID_W)) cafl_top_i (.CLK(clk), .SRST(srst),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK_O(ack),
        .FRAME_VALID(fv), .FRAME_ID(fid), .BUSY(busy), .BUF0_LOAD(ld0),
        .BUF1_LOAD(ld1), .BUF0_FULL(full0), .BUF1_FULL(full1),
        .BUF0_ID(id0), .BUF1_ID(id1), .BUF0_HIT(hit0), .BUF1_HIT(hit1));
    cafl_frame_src #(.ID_W(ID_W)) cafl_frame_src_i (.CLK(clk),
        .SRST(srst), .GO(go), .ID_IN(gid), .BUSY(busy),
        .FRAME_VALID(fv), .FRAME_ID(fid));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task give_verdict;
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000)
        begin
            err_total++;
            give_verdict();
        end
    end

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
            err_total++;
        end
    endtask

    // The request stands until ack is seen at a rising edge; only the
    // bench timeout ends a wait that never gets its answer.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, dati} <= {1'b1, 1'b1, w, a, d};
        do
        begin
            @(posedge clk);
        end
        while (ack !== 1'b1);
        q = dato;
        {cyc, stb, we} <= 3'h0;
        @(posedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    // A frame is loaded three edges after it is taken; six cover it.
    task frm(input logic [ID_W-1:0] id, input logic e0, input logic e1);
        @(posedge clk);
        go <= 1'b1;
        gid <= id;
        @(posedge clk);
        go <= 1'b0;
        {l0, l1} = 2'h0;
        repeat (6)
        begin
            @(posedge clk);
            #1;
            l0 |= ld0;
            l1 |= ld1;
        end
        chk(l0, e0);
        chk(l1, e1);
    endtask

    initial
    begin
        srst = 1'b1;
        {cyc, stb, we, go, adr, dati, gid} = '0;
        sel = 4'hf;
        {err_total, n_checks, cyc_cnt} = {32'h0, 32'h0, 32'h0};
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rd(`CAFL_OFF_CTRL, 32'h1);
        rd(8'h80, 32'h0);
        wr(`CAFL_OFF_MASK0, 32'h7f0);
        wr(`CAFL_OFF_MASK1, 32'h7ff);
        // Lane 1 alone may change only the upper identifier bits.
        sel <= 4'h2;
        wr(`CAFL_OFF_MASK1, 32'h0000_0300);
        sel <= 4'hf;
        rd(`CAFL_OFF_MASK1, 32'h3ff);
        wr(`CAFL_OFF_MASK1, 32'h7ff);
        for (int i = 0; i < 6; i++)
            wr(`CAFL_OFF_FILT_BASE + 8'(4 * i), flt[i]);
        rd(`CAFL_OFF_FILT_BASE + 8'h14, 32'h555);
        wr(`CAFL_OFF_CTRL, 32'h0);
        rd(`CAFL_OFF_FILT_BASE + 8'h14, 32'h0);
        rd(`CAFL_OFF_MASK0, 32'h0);
        wr(`CAFL_OFF_FILT_BASE + 8'h14, 32'h0);
        $display("test registers done errors=%0d", err_total);
        frm(11'h12a, 1'b1, 1'b0);
        chk(id0, 32'h12a);
        chk(hit0, 32'h0);
        chk(full0, 32'h1);
        frm(11'h131, 1'b0, 1'b0);
        wr(`CAFL_OFF_CTRL, 32'h2);
        frm(11'h131, 1'b0, 1'b1);
        chk(hit1, 32'h1);
        chk(id1, 32'h131);
        rd(`CAFL_OFF_BUF0_CTL, 32'hf);
        frm(11'h200, 1'b0, 1'b0);
        rd(`CAFL_OFF_STATUS, 32'h7);
        wr(`CAFL_OFF_BUF0_CTL, 32'h8);
        wr(`CAFL_OFF_BUF1_CTL, 32'h8);
        chk(full1, 32'h0);
        $display("test rollover done errors=%0d", err_total);
        frm(11'h200, 1'b0, 1'b1);
        chk(hit1, 32'h2);
        wr(`CAFL_OFF_BUF1_CTL, 32'h8);
        frm(11'h301, 1'b0, 1'b0);
        frm(11'h300, 1'b0, 1'b1);
        chk(hit1, 32'h3);
        wr(`CAFL_OFF_BUF1_CTL, 32'h8);
        frm(11'h555, 1'b0, 1'b1);
        chk(hit1, 32'h5);
        $display("test buffer one done errors=%0d", err_total);
        give_verdict();
    end
endmodule
